// >>> rtl/psv_params.svh
// constants for the program sequencer: addresses, widths, reset values
`ifndef PSV_PARAMS_SVH
`define PSV_PARAMS_SVH
`define PSV_PC_W 11
`define PSV_RESET_VEC 11'h000
`define PSV_IRQ_VEC 11'h008
`define PSV_RSVD_BASE 11'h7FD
`define PSV_STACK_DEPTH 8
`define PSV_SP_W 3
`define PSV_FLAG_HI_POR 1'b1
`define PSV_FLAG_PD_POR 1'b0
`define PSV_FLAG_HI_WDT 1'b0
`define PSV_FLAG_PD_WDT 1'b0
`define PSV_FLAG_HI_EXT 1'b1
`define PSV_FLAG_PD_EXT 1'b1
`define PSV_FLAGS_W 6
`endif

// >>> rtl/psv_pkg.sv
// types for the program sequencer
package psv_pkg;
  // sequencing operations presented by the decoder, one per instruction cycle
  typedef enum logic [3:0] {
    PSV_OP_NEXT = 4'h0,
    PSV_OP_JUMP = 4'h1,
    PSV_OP_CALL = 4'h2,
    PSV_OP_RET = 4'h3,
    PSV_OP_RETURN_FROM_INTERRUPT = 4'h4,
    PSV_OP_PCL_ADD = 4'h5,
    PSV_OP_PCL_SUB = 4'h6,
    PSV_OP_SAVE = 4'h7,
    PSV_OP_RESTORE = 4'h8,
    PSV_OP_TABLE = 4'h9
  } psv_op_t;
  // table read state
  typedef enum logic [0:0] {
    PSV_ST_RUN = 1'b0,
    PSV_ST_TBL = 1'b1
  } psv_state_t;
endpackage : psv_pkg

// >>> rtl/psv_sequencer.sv
// program address sequencer: vectors, reset cause, save buffer, table read, pc add
`timescale 1ns/10ps
`include "psv_params.svh"
module psv_sequencer #(
  parameter int PC_W = `PSV_PC_W,
  parameter int DEPTH = `PSV_STACK_DEPTH
) (
  input wire logic ref_clk, // instruction clock, 25 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic por_event, // power-on reset happened (held with rst_n)
  input wire logic wdt_event, // watchdog overflow reset happened
  input wire logic ext_event, // external reset pin reset happened
  input wire logic step_en, // one instruction cycle completes
  input wire logic [3:0] op, // sequencing operation, psv_pkg::psv_op_t
  input wire logic [PC_W-1:0] jump_addr, // target for jump and call
  input wire logic irq_take, // service an interrupt this cycle
  input wire logic [7:0] acc_in, // accumulator value from the alu
  input wire logic [5:0] flags_in, // low six flag bits from the alu
  input wire logic [7:0] ptr_hi, // table pointer high byte
  input wire logic [7:0] ptr_lo, // table pointer low byte
  input wire logic [15:0] rom_data, // word returned by the program rom
  output logic [PC_W-1:0] rom_addr, // program rom address
  output logic [PC_W-1:0] pc, // current program counter
  output logic [7:0] pc_low_byte, // low pc byte
  output logic [2:0] pc_high_bits, // high pc bits
  output logic reset_cause_flag_hi, // first reset cause flag
  output logic powerdown_cause_flag, // second reset cause flag
  output logic [7:0] accumulator, // accumulator load value
  output logic acc_load, // pulse: load accumulator
  output logic [5:0] flags_out, // restored flags
  output logic flags_load, // pulse: load flags
  output logic [7:0] table_hi, // table-read high register
  output logic tbl_busy, // table read in progress, fetch stalled
  output logic pc_in_reserved, // pc points at the reserved tail
  output logic stack_overflow // push beyond stack depth
);
  localparam int SP_W = $clog2(DEPTH);
  // decoded operation and table-read state
  psv_pkg::psv_op_t op_e;
  psv_pkg::psv_state_t state;
  psv_pkg::psv_state_t next_state;
  // program counter and the return stack
  logic [PC_W-1:0] next_pc;
  logic [PC_W-1:0] stack [DEPTH];
  logic [PC_W-1:0] next_top;
  logic [SP_W-1:0] sp;
  logic [SP_W-1:0] next_sp;
  logic push;
  logic pop;
  logic full;
  logic next_full;
  logic ovf;
  logic next_ovf;
  // table read address held across the stall cycle
  logic [PC_W-1:0] tbl_addr;
  logic [PC_W-1:0] next_tbl_addr;
  // one-level save buffer
  logic [7:0] save_acc;
  logic [7:0] next_save_acc;
  logic [5:0] save_flags;
  logic [5:0] next_save_flags;
  // accumulator, flag and table-high results
  logic [7:0] next_acc;
  logic [7:0] next_table_hi;
  logic [5:0] next_flags;
  logic next_acc_load;
  logic next_flags_load;
  // reset cause state
  logic cause_hi;
  logic cause_pd;
  logic next_cause_hi;
  logic next_cause_pd;
  logic cause_seen;
  logic next_cause_seen;

  // the pc high part only ever counts up; a borrow never reaches it
  // the low byte simply wraps on a borrow, so a jump table placed
  // across a 256-word boundary lands in the wrong page when going down
  function automatic logic [PC_W-1:0] pcl_arith(input logic [PC_W-1:0] p,
                                                  input logic [7:0] a,
                                                  input logic sub);
    logic [8:0] s;
    logic [PC_W-9:0] h;
    s = sub ? ({1'b0, p[7:0]} - {1'b0, a}) : ({1'b0, p[7:0]} + {1'b0, a});
    h = p[PC_W-1:8];
    if (!sub && s[8]) begin
      h = h + 1'b1;
    end
    return {h, s[7:0]};
  endfunction : pcl_arith

  // operation decode; codes above the table read fall to a plain step
  assign op_e = psv_pkg::psv_op_t'(op);

  // pc views for the fetch path
  assign pc_low_byte = pc[7:0];
  assign pc_high_bits = pc[PC_W-1:8];

  // the rom sees the table pointer only during the one stall cycle
  assign rom_addr = (state == psv_pkg::PSV_ST_TBL) ? tbl_addr : pc;
  assign tbl_busy = (state == psv_pkg::PSV_ST_TBL);

  // status views
  assign reset_cause_flag_hi = cause_hi;
  assign powerdown_cause_flag = cause_pd;
  assign pc_in_reserved = (pc >= PC_W'(`PSV_RSVD_BASE));
  assign stack_overflow = ovf;

  // pc sequencing and push/pop requests
  // an interrupt wins over the decoded operation in the same cycle, so the
  // operation is dropped rather than half done; the decoder must repeat it
  always_comb begin
    next_pc = pc;
    next_state = state;
    next_tbl_addr = tbl_addr;
    push = 1'b0;
    pop = 1'b0;
    next_top = pc;
    if (state == psv_pkg::PSV_ST_TBL) begin
      next_state = psv_pkg::PSV_ST_RUN; // rom answered, pc resumes
    end else if (step_en) begin
      if (irq_take) begin
        push = 1'b1;
        next_top = pc;
        next_pc = PC_W'(`PSV_IRQ_VEC);
      end else begin
        next_pc = pc + 1'b1;
        unique case (op_e)
          psv_pkg::PSV_OP_JUMP: next_pc = jump_addr;
          psv_pkg::PSV_OP_CALL: begin
            push = 1'b1;
            next_top = pc + 1'b1;
            next_pc = jump_addr;
          end
          psv_pkg::PSV_OP_RET, psv_pkg::PSV_OP_RETURN_FROM_INTERRUPT: begin
            pop = 1'b1;
            next_pc = stack[sp - 1'b1];
          end
          psv_pkg::PSV_OP_PCL_ADD: next_pc = pcl_arith(pc, acc_in, 1'b0);
          psv_pkg::PSV_OP_PCL_SUB: next_pc = pcl_arith(pc, acc_in, 1'b1);
          psv_pkg::PSV_OP_TABLE: begin
            // only the low address bits reach the 2K rom; no pointer carry
            next_tbl_addr = PC_W'({ptr_hi, ptr_lo});
            next_state = psv_pkg::PSV_ST_TBL;
          end
          default: next_pc = pc + 1'b1;
        endcase
      end
    end
  end

  // reset restarts at the reset vector
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_W'(`PSV_RESET_VEC);
      state <= psv_pkg::PSV_ST_RUN;
      tbl_addr <= '0;
    end else begin
      pc <= next_pc;
      state <= next_state;
      tbl_addr <= next_tbl_addr;
    end
  end

  // stack pointer and depth tracking; all levels fill before overflow
  // a push onto a full stack overwrites the oldest entry, as the pointer
  // wraps; the sticky flag is the only trace software debug can see
  always_comb begin
    next_sp = sp;
    next_full = full;
    next_ovf = ovf;
    if (push) begin
      next_sp = sp + 1'b1;
      if (full) begin
        next_ovf = 1'b1; // sticky until the next reset
      end
      if (sp == SP_W'(DEPTH - 1)) begin
        next_full = 1'b1; // every level now holds a return address
      end
    end else if (pop) begin
      next_sp = sp - 1'b1;
      next_full = 1'b0;
    end
  end

  // stack pointer registers; the stack starts empty after any reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= '0;
      full <= 1'b0;
      ovf <= 1'b0;
    end else begin
      sp <= next_sp;
      full <= next_full;
      ovf <= next_ovf;
    end
  end

  // stack storage has no reset; entries are written before being read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      stack[sp] <= next_top;
    end
  end

  // save buffer, table result and accumulator/flag loads
  always_comb begin
    next_save_acc = save_acc;
    next_save_flags = save_flags;
    next_acc = accumulator;
    next_flags = flags_out;
    next_table_hi = table_hi;
    next_acc_load = 1'b0;
    next_flags_load = 1'b0;
    if (state == psv_pkg::PSV_ST_TBL) begin
      next_acc = rom_data[7:0];
      next_table_hi = rom_data[15:8];
      next_acc_load = 1'b1;
    end else if (step_en && !irq_take) begin
      if (op_e == psv_pkg::PSV_OP_SAVE) begin
        next_save_acc = acc_in;
        next_save_flags = flags_in; // cause bits are never saved
      end else if (op_e == psv_pkg::PSV_OP_RESTORE) begin
        next_acc = save_acc;
        next_flags = save_flags;
        next_acc_load = 1'b1;
        next_flags_load = 1'b1;
      end
    end
  end

  // save buffer and result registers; loads are one-cycle pulses
  // the cause flags live in their own group so a restore never touches them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      save_acc <= 8'h00;
      save_flags <= 6'h00;
      accumulator <= 8'h00;
      flags_out <= 6'h00;
      table_hi <= 8'h00;
      acc_load <= 1'b0;
      flags_load <= 1'b0;
    end else begin
      save_acc <= next_save_acc;
      save_flags <= next_save_flags;
      accumulator <= next_acc;
      flags_out <= next_flags;
      table_hi <= next_table_hi;
      acc_load <= next_acc_load;
      flags_load <= next_flags_load;
    end
  end

  // reset cause: latched once on the first edge after release from the event inputs
  always_comb begin
    next_cause_hi = cause_hi;
    next_cause_pd = cause_pd;
    next_cause_seen = 1'b1;
    if (!cause_seen) begin
      if (por_event) begin
        next_cause_hi = `PSV_FLAG_HI_POR;
        next_cause_pd = `PSV_FLAG_PD_POR;
      end else if (wdt_event) begin
        next_cause_hi = `PSV_FLAG_HI_WDT;
        next_cause_pd = `PSV_FLAG_PD_WDT;
      end else if (ext_event) begin
        next_cause_hi = `PSV_FLAG_HI_EXT;
        next_cause_pd = `PSV_FLAG_PD_EXT;
      end
    end
  end

  // reset cause registers; they hold the power-on values while in reset
  // limitation: an event level that arrives late is missed, by design
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_seen <= 1'b0;
      cause_hi <= `PSV_FLAG_HI_POR;
      cause_pd <= `PSV_FLAG_PD_POR;
    end else begin
      cause_seen <= next_cause_seen;
      cause_hi <= next_cause_hi;
      cause_pd <= next_cause_pd;
    end
  end
endmodule : psv_sequencer

// >>> testbench/psv_rom_model.sv
// program rom model answering its address at once
`timescale 1ns/10ps
module psv_rom_model (
  input wire logic [10:0] addr, // rom address
  output logic [15:0] data // rom word
);
  // halves differ per address so a swapped byte shows
  assign data = {addr[7:0] ^ 8'ha5, addr[10:3]};
endmodule : psv_rom_model

// >>> testbench/psv_sequencer_sva.sv
// port assertions for the program sequencer
`timescale 1ns/10ps
module psv_sva #(
  parameter int PC_W = 11
) (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic step_en, // step
  input wire logic [3:0] op, // operation
  input wire logic irq_take, // interrupt
  input wire logic [7:0] acc_in, // acc in
  input wire logic [7:0] ptr_hi, // ptr high
  input wire logic [7:0] ptr_lo, // ptr low
  input wire logic [15:0] rom_data, // rom word
  input wire logic [PC_W-1:0] rom_addr, // rom address
  input wire logic [PC_W-1:0] pc, // pc
  input wire logic [7:0] pc_low_byte, // pc low
  input wire logic [2:0] pc_high_bits, // pc high
  input wire logic [7:0] accumulator, // acc out
  input wire logic acc_load, // acc pulse
  input wire logic flags_load, // flags pulse
  input wire logic [7:0] table_hi, // table high
  input wire logic tbl_busy, // table busy
  input wire logic pc_in_reserved // reserved flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // low byte sum with carry, and a plain accepted step
  logic [8:0] sum;
  logic go;
  assign sum = pc_low_byte + acc_in;
  assign go = step_en && !tbl_busy && !irq_take;
  sequence s_tbl; go && op == 4'h9; endsequence
  sequence s_fill; tbl_busy ##1 (!tbl_busy && acc_load); endsequence
  chk_tbl_steps: assert property (s_tbl |=> s_fill)
    else $error("table read steps wrong");
  chk_tbl_data: assert property (tbl_busy |=>
    {table_hi, accumulator} == $past(rom_data)) else $error("table word wrong");
  chk_tbl_addr: assert property (tbl_busy |-> rom_addr == {ptr_hi[2:0], ptr_lo})
    else $error("table address wrong");
  chk_irq_vec: assert property (step_en && !tbl_busy && irq_take |=> pc == 11'h008)
    else $error("irq vector wrong");
  chk_pcl_add: assert property (go && op == 4'h5 |=>
    pc == $past({pc_high_bits + sum[8], sum[7:0]})) else $error("pc add wrong");
  chk_pcl_sub: assert property (go && op == 4'h6 |=>
    pc == $past({pc_high_bits, pc_low_byte - acc_in})) else $error("pc sub wrong");
  chk_rsvd_flag: assert property (pc_in_reserved == (pc >= 11'h7fd))
    else $error("reserved flag wrong");
  chk_reset_pc: assert property ($rose(rst_n) |-> pc == 11'h000 && !acc_load)
    else $error("reset state wrong");
  chk_restore_ld: assert property (go && op == 4'h8 |=> ##[0:1] acc_load && flags_load)
    else $error("restore pulses missing");
endmodule : psv_sva
bind psv_sequencer psv_sva #(.PC_W(PC_W)) i_psv_sva (.*);

// >>> testbench/psv_sequencer_tb.sv
// self-checking bench for the program sequencer
`timescale 1ns/10ps
module psv_sequencer_tb;
  logic ref_clk = 0, rst_n = 0, por_event = 0, wdt_event = 0, ext_event = 0;
  logic step_en = 0, irq_take = 0, reset_cause_flag_hi, powerdown_cause_flag;
  logic acc_load, flags_load, tbl_busy, pc_in_reserved, stack_overflow;
  logic [3:0] op = 0;
  logic [10:0] jump_addr = 0, rom_addr, pc, exp_pc;
  logic [7:0] acc_in = 0, ptr_hi = 0, ptr_lo = 0, pc_low_byte, accumulator, table_hi, sav;
  logic [7:0] lfsr = 8'h4a; // starts at 74
  logic [5:0] flags_in = 0, flags_out;
  logic [15:0] rom_data;
  logic [2:0] pc_high_bits;
  int failures = 0, n_tests = 0, cycles = 0;
  psv_sequencer i_psv_sequencer (.*);
  psv_rom_model i_psv_rom_model (.addr(rom_addr), .data(rom_data));
  initial forever #20 ref_clk = ~ref_clk;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  function automatic logic [10:0] arith(logic [10:0] p, logic [7:0] a, logic sub);
    // borrow never reaches the high bits, carry does
    if (sub) return {p[10:8], p[7:0] - a};
    return {p[10:8] + (p[7:0] + a > 255), p[7:0] + a};
  endfunction : arith
  task automatic summarize();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // one accepted step, then an idle cycle so strobes never toggle twice
  task automatic step(logic [3:0] o, logic [10:0] a = 0, logic irq = 0);
    op = o;
    jump_addr = a;
    irq_take = irq;
    step_en = 1;
    @(posedge ref_clk) #1;
    step_en = 0;
    irq_take = 0;
    @(posedge ref_clk) #1;
  endtask : step
  task automatic do_reset(int c);
    rst_n = 0;
    {por_event, wdt_event, ext_event} = 3'b100 >> c;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1;
    @(posedge ref_clk) #1;
    {por_event, wdt_event, ext_event} = 3'b000;
  endtask : do_reset
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    for (int c = 0; c < 3; c++) begin
      do_reset(c);
      chk({reset_cause_flag_hi, powerdown_cause_flag}, {c != 1, c == 2});
      chk(pc, 0);
    end
    $display("test reset done");
    // jumps near the reserved tail and pc arithmetic, carry first
    for (int i = 0; i < 40; i++) begin
      acc_in = rnd();
      exp_pc = (i == 0) ? 11'h0ff : (i < 3) ? 11'h7fe - i[1:0] : {acc_in[2:0], rnd()};
      step(4'h1, exp_pc); // first step after reset is a jump
      chk(pc_in_reserved, exp_pc >= 11'h7fd);
      acc_in = (i == 0) ? 8'h01 : rnd();
      step(i[0] ? 4'h6 : 4'h5);
      exp_pc = arith(exp_pc, acc_in, i[0]);
      chk(pc, exp_pc);
    end
    $display("test pc arithmetic done");
    step(4'h2, 11'h123);
    step(4'h0, 0, 1);
    chk(pc, 11'h008);
    step(4'h4);
    chk(pc, 11'h123);
    step(4'h3);
    step(4'h0);
    chk(pc, 11'(exp_pc + 11'h002));
    // eight levels fill without overflow, the ninth push overflows
    chk(stack_overflow, 0);
    repeat (8) step(4'h2, 11'h010);
    chk(stack_overflow, 0);
    step(4'h2, 11'h010);
    chk(stack_overflow, 1);
    $display("test call and interrupt done");
    sav = rnd();
    acc_in = sav;
    flags_in = 6'h2a;
    step(4'h7);
    acc_in = ~sav;
    flags_in = 6'h15;
    step(4'h8);
    chk({flags_out, accumulator}, {6'h2a, sav});
    // table reads on both sides of a low pointer wrap, high byte held
    ptr_hi = rnd();
    for (int k = 0; k < 2; k++) begin
      ptr_lo = k ? 8'h00 : 8'hff;
      step(4'h9);
      repeat (2) @(posedge ref_clk) #1;
      chk({table_hi, accumulator}, {ptr_lo ^ 8'ha5, ptr_hi[2:0], ptr_lo[7:3]});
    end
    $display("test save and table done");
    summarize();
  end
endmodule : psv_sequencer_tb
